/* core/agu_defines.svh */
/*
  Offsets, field positions, reset values and response codes for the address generation extension block.
  Assumes inclusion by bare name from the core module.
*/
`ifndef AGU_DEFINES_SVH
`define AGU_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_MODCTL   5'h00
`define OFS_BITREV   5'h04
`define OFS_TBLPAGE  5'h08
`define OFS_VISPAGE  5'h0C
`define OFS_XSTART   5'h10
`define OFS_XEND     5'h14
`define OFS_YSTART   5'h18
`define OFS_YEND     5'h1C

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define XMOD_EN_BIT  15
`define YMOD_EN_BIT  14
`define BREV_EN_BIT  15
`define PTR_NONE     4'hF
`define CFG_SPACE_BIT 7
`define VIS_EN_BIT   2

// ----------------------------------------------------------------------------
// Reset values and response codes
// ----------------------------------------------------------------------------
`define RST_MODCTL   16'h00FF
`define RST_BITREV   16'h0000
`define RST_PAGE     8'h00
`define RST_BOUND    16'h0000
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

/* core/agu_pkg.sv */
/*
  Types shared by the address generation extension block.
  Includes no header and uses none of the defines.
*/
package agu_pkg;

  // ----------------------------------------------------------------------------
  // Address access modes
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INDIRECT = 3'h0,
    MODE_POST_INC = 3'h1,
    MODE_POST_DEC = 3'h2,
    MODE_PRE_INC  = 3'h3,
    MODE_PRE_DEC  = 3'h4,
    MODE_REG_OFS  = 3'h5
  } addr_mode_t;

  // ----------------------------------------------------------------------------
  // Address request and answer carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic       [3:0]  wreg;
    logic       [15:0] ptr;
    logic       [15:0] modifier;
    addr_mode_t        mode;
  } ea_req_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] wb_value;
    logic        wb_en;
  } ea_ans_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        config_space;
    logic        remap;
    logic        read_only;
  } prog_addr_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;

endpackage

/* core/agu_ext.sv */
/*
  Address generation extensions: modulo correction for the X read, X write and Y units, bit-reversed
  X write addresses, and program-space address construction for table and visibility accesses.
  Assumes the core presents each unit's request combinationally and samples the answer in the same
  cycle; registers are reached over AXI4-Lite on SYS_CLK.
*/
// Functional notes
// - X units correct the selected pointer when X select is not 15 and enabled.
// - Y unit corrects the selected pointer when Y select is not 15 and enabled.
// - Correction applies to whichever working register is selected, any of 0 to 14; select 15 turns it off.
// - Incrementing past upper or decrementing past lower bound counts as crossing.
// - Corrected address written back only for pre or post modify modes.
// - Bit reversal only in X write unit, never for reads.
// - Pointer and modifier are both mirrored before the add; the sum is mirrored back.
// - Reversal needs select not 15, enable bit set, pre or post increment.
// - Pivot is a 15-bit word quantity scaled to byte addresses.
// - Byte writes or other modes get the normal address while reversal enabled.
// - Active reversal adds reversed modifier instead of increment; LSB forced zero.
// - Reversal beats modulo in X write unit; modulo stays in X read unit.
// - Reversal mirrors the index bit order, 1 gives 8, 3 gives 12.
// - Table address is 8-bit page above the 16-bit effective address.
// - Page top bit zero selects user memory, one selects configuration memory.
// - High data address forms 23-bit address from visibility page and 15 bits.
// - Remapped address bit 15 comes from visibility page bit 0.
// - Remapped accesses are read-only and return the low program word.
// - Table addresses need no word alignment; reads reach configuration space.
// - Four 16-bit boundary registers hold X and Y start and end.
// - Remapping happens only with the visibility enable bit of core control set.
`timescale 1ns/1ps
`include "agu_defines.svh"

module agu_ext (
  // Clock and reset
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_N,
  // AXI4-Lite slave
  input  wire logic [4:0]            S_AWADDR,
  input  wire logic                  S_AWVALID,
  output logic                       S_AWREADY,
  input  wire logic [31:0]           S_WDATA,
  input  wire logic [3:0]            S_WSTRB,
  input  wire logic                  S_WVALID,
  output logic                       S_WREADY,
  output logic [1:0]                 S_BRESP,
  output logic                       S_BVALID,
  input  wire logic                  S_BREADY,
  input  wire logic [4:0]            S_ARADDR,
  input  wire logic                  S_ARVALID,
  output logic                       S_ARREADY,
  output logic [31:0]                S_RDATA,
  output logic [1:0]                 S_RRESP,
  output logic                       S_RVALID,
  input  wire logic                  S_RREADY,
  // Address unit requests and answers
  input  wire agu_pkg::ea_req_t      XRD_REQ,
  output agu_pkg::ea_ans_t           XRD_ANS,
  input  wire agu_pkg::ea_req_t      XWR_REQ,
  input  wire logic                  XWR_BYTE,
  output agu_pkg::ea_ans_t           XWR_ANS,
  input  wire agu_pkg::ea_req_t      Y_REQ,
  output agu_pkg::ea_ans_t           Y_ANS,
  // Program space address construction
  input  wire logic [15:0]           DATA_EA,
  input  wire logic                  TABLE_OP,
  input  wire logic                  VISIBILITY_ENABLE,
  output agu_pkg::prog_addr_t        PROG_ADDR
);

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [15:0] modctl_r;
  logic [15:0] bitrev_r;
  logic [7:0]  tblpage_r;
  logic [7:0]  vispage_r;
  logic [15:0] bound_r [4];
  agu_pkg::bus_state_t wst_r;
  agu_pkg::bus_state_t rst_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [4:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        rmapped;
  logic [31:0] rdata_nxt;
  logic        wr_fire;
  logic        wr_hit;

  assign S_AWREADY = (wst_r == agu_pkg::BUS_IDLE) && !aw_got_r;
  assign S_WREADY  = (wst_r == agu_pkg::BUS_IDLE) && !w_got_r;
  assign S_ARREADY = (rst_r == agu_pkg::BUS_IDLE);
  assign S_BVALID  = (wst_r == agu_pkg::BUS_RESP);
  assign S_RVALID  = (rst_r == agu_pkg::BUS_RESP);
  assign wr_fire   = aw_got_r && w_got_r;
  assign wr_hit    = (awaddr_r[1:0] == 2'h0) && (awaddr_r[4:2] <= 3'h7);

  // ----------------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wst_r    <= agu_pkg::BUS_IDLE;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 5'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      S_BRESP  <= `RESP_OKAY;
    end else begin
      case (wst_r)
        agu_pkg::BUS_IDLE: begin
          if (S_AWVALID && S_AWREADY) begin
            aw_got_r <= 1'b1;
            awaddr_r <= S_AWADDR;
          end
          if (S_WVALID && S_WREADY) begin
            w_got_r <= 1'b1;
            wdata_r <= S_WDATA;
            wstrb_r <= S_WSTRB;
          end
          if (wr_fire) begin
            wst_r    <= agu_pkg::BUS_RESP;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            S_BRESP  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        agu_pkg::BUS_RESP: begin
          if (S_BREADY) begin
            wst_r <= agu_pkg::BUS_IDLE;
          end
        end
        default: wst_r <= agu_pkg::BUS_IDLE;
      endcase
    end
  end

  // Byte lanes 0 and 1 carry the 16-bit registers; upper lanes are ignored.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      modctl_r  <= `RST_MODCTL;
      bitrev_r  <= `RST_BITREV;
      tblpage_r <= `RST_PAGE;
      vispage_r <= `RST_PAGE;
    end else if (wst_r == agu_pkg::BUS_IDLE && wr_fire && wr_hit) begin
      case (awaddr_r)
        `OFS_MODCTL: begin
          if (wstrb_r[0]) modctl_r[7:0]  <= wdata_r[7:0];
          if (wstrb_r[1]) modctl_r[15:8] <= wdata_r[15:8];
        end
        `OFS_BITREV: begin
          if (wstrb_r[0]) bitrev_r[7:0]  <= wdata_r[7:0];
          if (wstrb_r[1]) bitrev_r[15:8] <= wdata_r[15:8];
        end
        `OFS_TBLPAGE: if (wstrb_r[0]) tblpage_r <= wdata_r[7:0];
        `OFS_VISPAGE: if (wstrb_r[0]) vispage_r <= wdata_r[7:0];
        default: ;
      endcase
    end
  end

  // Boundary registers: X start, X end, Y start, Y end.
  generate
    for (genvar gi = 0; gi < 4; gi++) begin : g_bound
      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          bound_r[gi] <= `RST_BOUND;
        end else if (wst_r == agu_pkg::BUS_IDLE && wr_fire && wr_hit
                     && awaddr_r == (`OFS_XSTART + 5'(gi * 4))) begin
          if (wstrb_r[0]) bound_r[gi][7:0]  <= wdata_r[7:0];
          if (wstrb_r[1]) bound_r[gi][15:8] <= wdata_r[15:8];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rmapped   = 1'b1;
    case (S_ARADDR)
      `OFS_MODCTL:  rdata_nxt = {16'h0000, modctl_r};
      `OFS_BITREV:  rdata_nxt = {16'h0000, bitrev_r};
      `OFS_TBLPAGE: rdata_nxt = {24'h000000, tblpage_r};
      `OFS_VISPAGE: rdata_nxt = {24'h000000, vispage_r};
      `OFS_XSTART:  rdata_nxt = {16'h0000, bound_r[0]};
      `OFS_XEND:    rdata_nxt = {16'h0000, bound_r[1]};
      `OFS_YSTART:  rdata_nxt = {16'h0000, bound_r[2]};
      `OFS_YEND:    rdata_nxt = {16'h0000, bound_r[3]};
      default:      rmapped   = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_r   <= agu_pkg::BUS_IDLE;
      S_RDATA <= 32'h0000_0000;
      S_RRESP <= `RESP_OKAY;
    end else begin
      case (rst_r)
        agu_pkg::BUS_IDLE: begin
          if (S_ARVALID) begin
            rst_r   <= agu_pkg::BUS_RESP;
            S_RDATA <= rdata_nxt;
            S_RRESP <= rmapped ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        agu_pkg::BUS_RESP: if (S_RREADY) rst_r <= agu_pkg::BUS_IDLE;
        default: rst_r <= agu_pkg::BUS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Address computation
  // ----------------------------------------------------------------------------
  // Modulo step with boundary wrap; a jump past a boundary still wraps.
  function automatic agu_pkg::ea_ans_t modulo_step(input agu_pkg::ea_req_t req, input logic mod_on,
                                                   input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0]     nxt;
    logic [15:0]     ea;
    logic            up;
    logic            down;
    agu_pkg::ea_ans_t ans;
    nxt  = req.ptr;
    up   = 1'b0;
    down = 1'b0;
    case (req.mode)
      agu_pkg::MODE_POST_INC, agu_pkg::MODE_PRE_INC: begin
        nxt = req.ptr + req.modifier;
        up  = 1'b1;
      end
      agu_pkg::MODE_POST_DEC, agu_pkg::MODE_PRE_DEC: begin
        nxt  = req.ptr - req.modifier;
        down = 1'b1;
      end
      agu_pkg::MODE_REG_OFS: begin
        nxt = req.ptr + req.modifier;
        up  = !req.modifier[15];
        down = req.modifier[15];
      end
      default: nxt = req.ptr;
    endcase
    if (mod_on && up && nxt > hi) begin
      nxt = nxt - (hi - lo) - 16'h0001;
    end else if (mod_on && down && nxt < lo) begin
      nxt = nxt + (hi - lo) + 16'h0001;
    end
    case (req.mode)
      agu_pkg::MODE_PRE_INC, agu_pkg::MODE_PRE_DEC, agu_pkg::MODE_REG_OFS: ea = nxt;
      default: ea = req.ptr;
    endcase
    ans.ea       = ea;
    ans.wb_value = nxt;
    ans.wb_en    = (req.mode != agu_pkg::MODE_INDIRECT) && (req.mode != agu_pkg::MODE_REG_OFS);
    return ans;
  endfunction

  logic [14:0]      pivot;
  logic [15:0]      pivot_rev;
  logic [15:0]      ptr_rev;
  logic [15:0]      rev_sum;
  logic [15:0]      brev_raw;
  logic [15:0]      brev_sum;
  logic             x_mod_on_rd;
  logic             x_mod_on_wr;
  logic             y_mod_on;
  logic             brev_active;
  agu_pkg::ea_ans_t xwr_mod;

  assign pivot = bitrev_r[14:0];

  // Reverse-carry add: pointer and byte-scaled pivot are mirrored, added, and the sum mirrored back.
  generate
    for (genvar gb = 0; gb < 16; gb++) begin : g_rev
      assign ptr_rev[gb]  = XWR_REQ.ptr[15 - gb];
      assign brev_raw[gb] = rev_sum[15 - gb];
      if (gb < 15) begin : g_piv
        assign pivot_rev[gb] = pivot[14 - gb];
      end
    end
  endgenerate
  assign pivot_rev[15] = 1'b0;
  assign rev_sum       = ptr_rev + pivot_rev;
  assign brev_sum      = brev_raw & 16'hFFFE;

  assign x_mod_on_rd = modctl_r[`XMOD_EN_BIT] && (modctl_r[3:0] != `PTR_NONE)
                       && (XRD_REQ.wreg == modctl_r[3:0]);
  assign brev_active = (modctl_r[11:8] != `PTR_NONE) && bitrev_r[`BREV_EN_BIT] && !XWR_BYTE
                       && (XWR_REQ.wreg == modctl_r[11:8])
                       && (XWR_REQ.mode == agu_pkg::MODE_PRE_INC
                           || XWR_REQ.mode == agu_pkg::MODE_POST_INC);
  assign x_mod_on_wr = modctl_r[`XMOD_EN_BIT] && (modctl_r[3:0] != `PTR_NONE)
                       && (XWR_REQ.wreg == modctl_r[3:0]) && !brev_active;
  assign y_mod_on    = modctl_r[`YMOD_EN_BIT] && (modctl_r[7:4] != `PTR_NONE)
                       && (Y_REQ.wreg == modctl_r[7:4]);

  assign XRD_ANS = modulo_step(XRD_REQ, x_mod_on_rd, bound_r[0], bound_r[1]);
  assign xwr_mod = modulo_step(XWR_REQ, x_mod_on_wr, bound_r[0], bound_r[1]);
  assign Y_ANS   = modulo_step(Y_REQ, y_mod_on, bound_r[2], bound_r[3]);

  always_comb begin
    XWR_ANS = xwr_mod;
    if (brev_active) begin
      XWR_ANS.wb_value = brev_sum;
      XWR_ANS.wb_en    = 1'b1;
      XWR_ANS.ea       = (XWR_REQ.mode == agu_pkg::MODE_PRE_INC) ? brev_sum : (XWR_REQ.ptr & 16'hFFFE);
    end
  end

  // ----------------------------------------------------------------------------
  // Program space address construction
  // ----------------------------------------------------------------------------
  always_comb begin
    PROG_ADDR = '0;
    if (TABLE_OP) begin
      PROG_ADDR.addr         = {tblpage_r, DATA_EA};
      PROG_ADDR.config_space = tblpage_r[`CFG_SPACE_BIT];
    end else if (DATA_EA[15] && VISIBILITY_ENABLE) begin
      PROG_ADDR.addr      = {1'b0, vispage_r[7:1], vispage_r[0], DATA_EA[14:0]};
      PROG_ADDR.remap     = 1'b1;
      PROG_ADDR.read_only = 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  property p_wb_mode;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (Y_REQ.mode == agu_pkg::MODE_REG_OFS) |-> !Y_ANS.wb_en;
  endproperty
  a_wb_mode: assert property (p_wb_mode) else $error("offset mode wrote pointer back");

  property p_remap_top;
    @(posedge SYS_CLK) disable iff (!RST_N)
      PROG_ADDR.remap |-> (PROG_ADDR.addr[23] == 1'b0) && (PROG_ADDR.addr[15] == vispage_r[0]);
  endproperty
  a_remap_top: assert property (p_remap_top) else $error("remapped address bits wrong");

  property p_remap_en;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (!TABLE_OP && !VISIBILITY_ENABLE) |-> !PROG_ADDR.remap;
  endproperty
  a_remap_en: assert property (p_remap_en) else $error("remap without visibility enable");

  property p_table_cfg;
    @(posedge SYS_CLK) disable iff (!RST_N)
      TABLE_OP |-> (PROG_ADDR.config_space == tblpage_r[7]) && (PROG_ADDR.addr[15:0] == DATA_EA);
  endproperty
  a_table_cfg: assert property (p_table_cfg) else $error("table address wrong");

  property p_brev_lsb;
    @(posedge SYS_CLK) disable iff (!RST_N)
      brev_active |-> (XWR_ANS.wb_value[0] == 1'b0);
  endproperty
  a_brev_lsb: assert property (p_brev_lsb) else $error("reversed address LSB set");

  property p_brev_byte;
    @(posedge SYS_CLK) disable iff (!RST_N)
      (XWR_BYTE && !x_mod_on_wr && (XWR_REQ.mode == agu_pkg::MODE_POST_INC))
        |-> (XWR_ANS.ea == XWR_REQ.ptr) && (XWR_ANS.wb_value == XWR_REQ.ptr + XWR_REQ.modifier);
  endproperty
  a_brev_byte: assert property (p_brev_byte) else $error("reversal on byte write");

  property p_y_off;
    @(posedge SYS_CLK) disable iff (!RST_N)
      ((modctl_r[7:4] == 4'hF) && (Y_REQ.mode == agu_pkg::MODE_PRE_INC))
        |-> (Y_ANS.ea == Y_REQ.ptr + Y_REQ.modifier);
  endproperty
  a_y_off: assert property (p_y_off) else $error("Y modulo with select 15");

  property p_prio;
    @(posedge SYS_CLK) disable iff (!RST_N)
      brev_active |-> !x_mod_on_wr;
  endproperty
  a_prio: assert property (p_prio) else $error("modulo active with reversal");

  sequence s_bwait;
    S_BVALID && !S_BREADY;
  endsequence
  property p_bhold;
    @(posedge SYS_CLK) disable iff (!RST_N)
      s_bwait |=> S_BVALID;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

endmodule

/* testbench/agu_core_model.sv */
/*
  Core-side stand-in that presents address unit and program-space requests as held levels.
  Assumes the bench calls its tasks just after a rising SYS_CLK edge.
*/
`timescale 1ns/1ps
module agu_core_model (
  // Address unit requests
  output agu_pkg::ea_req_t xrd_req,
  output agu_pkg::ea_req_t xwr_req,
  output logic             xwr_byte,
  output agu_pkg::ea_req_t y_req,
  // Program space request
  output logic [15:0]      data_ea,
  output logic             table_op,
  output logic             vis_en
);
  initial begin
    {xrd_req, xwr_req, y_req, xwr_byte} = '0;
    {data_ea, table_op, vis_en} = '0;
  end
  // ------------
  // Request launch
  // ------------
  // Unit 0 is the X read unit, 1 the X write unit and 2 the Y unit.
  task automatic issue(input logic [1:0] u, input agu_pkg::ea_req_t r, input logic b);
    if (u == 2'h0)
      xrd_req <= r;
    else if (u == 2'h1)
      xwr_req <= r;
    else
      y_req <= r;
    xwr_byte <= b;
  endtask
  task automatic prog(input logic [15:0] ea, input logic t, input logic v);
    data_ea <= ea;
    table_op <= t;
    vis_en <= v;
  endtask
endmodule

/* testbench/agu_modulo_bitrev_progspace_tb.sv */
/*
  Self-checking bench: registers over AXI4-Lite, modulo, bit-reversed and program-space answers.
  Assumes the package and the core model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module agu_modulo_bitrev_progspace_tb;
  logic                sys_clk, rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic                s_awready, s_wready, s_bvalid, s_arready, s_rvalid, xwr_byte, table_op, vis_en;
  logic [4:0]          s_awaddr, s_araddr;
  logic [31:0]         s_wdata, s_rdata;
  logic [3:0]          s_wstrb;
  logic [1:0]          s_bresp, s_rresp;
  logic [15:0]         data_ea;
  agu_pkg::ea_req_t    xrd_req, xwr_req, y_req;
  agu_pkg::ea_ans_t    xrd_ans, xwr_ans, y_ans;
  agu_pkg::prog_addr_t prog_addr;
  logic [3:0]          sel [3] = '{4'h0, 4'hD, 4'h3};
  int                  fail_count = 0;
  int                  total_checks = 0;
  localparam agu_pkg::addr_mode_t m_ind = agu_pkg::MODE_INDIRECT, m_posti = agu_pkg::MODE_POST_INC;
  localparam agu_pkg::addr_mode_t m_postd = agu_pkg::MODE_POST_DEC, m_prei = agu_pkg::MODE_PRE_INC;
  localparam agu_pkg::addr_mode_t m_pred = agu_pkg::MODE_PRE_DEC, m_ofs = agu_pkg::MODE_REG_OFS;
  localparam logic [15:0]         base = 16'h1200;

  agu_ext agu_ext_inst (
    .SYS_CLK(sys_clk), .RST_N(rst_n),
    .S_AWADDR(s_awaddr), .S_AWVALID(s_awvalid), .S_AWREADY(s_awready),
    .S_WDATA(s_wdata), .S_WSTRB(s_wstrb), .S_WVALID(s_wvalid), .S_WREADY(s_wready),
    .S_BRESP(s_bresp), .S_BVALID(s_bvalid), .S_BREADY(s_bready),
    .S_ARADDR(s_araddr), .S_ARVALID(s_arvalid), .S_ARREADY(s_arready),
    .S_RDATA(s_rdata), .S_RRESP(s_rresp), .S_RVALID(s_rvalid), .S_RREADY(s_rready),
    .XRD_REQ(xrd_req), .XRD_ANS(xrd_ans), .XWR_REQ(xwr_req), .XWR_BYTE(xwr_byte), .XWR_ANS(xwr_ans),
    .Y_REQ(y_req), .Y_ANS(y_ans), .DATA_EA(data_ea), .TABLE_OP(table_op),
    .VISIBILITY_ENABLE(vis_en), .PROG_ADDR(prog_addr)
  );
  agu_core_model agu_core_model_inst (
    .xrd_req(xrd_req), .xwr_req(xwr_req), .xwr_byte(xwr_byte), .y_req(y_req),
    .data_ea(data_ea), .table_op(table_op), .vis_en(vis_en)
  );

  always #2.5 sys_clk = ~sys_clk;

  // ------------
  // Bus and request tasks
  // ------------
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ap, wp, bp, ta, tw, tb;
    ap = 1'b1;
    wp = 1'b1;
    bp = 1'b1;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (int n = 0; n < 50 && bp; n++) begin
      @(negedge sys_clk);
      ta = ap && s_awready;
      tw = wp && s_wready;
      tb = !ap && !wp && s_bvalid;
      if (tb)
        `CHK(s_bresp, er)
      @(posedge sys_clk);
      if (ta)
        s_awvalid <= 1'b0;
      if (tw)
        s_wvalid <= 1'b0;
      if (tb)
        s_bready <= 1'b0;
      ap = ap && !ta;
      wp = wp && !tw;
      bp = bp && !tb;
    end
    @(posedge sys_clk);
    `CHK(bp, 1'b0)
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ap, rp, ta, tr;
    ap = 1'b1;
    rp = 1'b1;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (int n = 0; n < 50 && rp; n++) begin
      @(negedge sys_clk);
      ta = ap && s_arready;
      tr = !ap && s_rvalid;
      if (tr) begin
        `CHK(s_rdata, ed)
        `CHK(s_rresp, er)
      end
      @(posedge sys_clk);
      if (ta)
        s_arvalid <= 1'b0;
      if (tr)
        s_rready <= 1'b0;
      ap = ap && !ta;
      rp = rp && !tr;
    end
    @(posedge sys_clk);
    `CHK(rp, 1'b0)
  endtask

  // Unit 3 is a byte-sized request to the X write unit.
  task automatic agu(input int u, input logic [3:0] w, input logic [15:0] p, input logic [15:0] m,
                     input agu_pkg::addr_mode_t md, input logic [15:0] ea, input logic [15:0] wb, input logic en);
    agu_pkg::ea_ans_t g;
    agu_core_model_inst.issue(2'((u == 3) ? 1 : u), '{w, p, m, md}, u == 3);
    @(negedge sys_clk);
    g = (u == 2) ? y_ans : (u == 0) ? xrd_ans : xwr_ans;
    `CHK(g.ea, ea)
    `CHK(g.wb_en, en)
    if (en)
      `CHK(g.wb_value, wb)
    @(posedge sys_clk);
  endtask

  task automatic prg(input logic [15:0] ea, input logic t, input logic v, input agu_pkg::prog_addr_t e);
    agu_core_model_inst.prog(ea, t, v);
    @(negedge sys_clk);
    `CHK(prog_addr.remap, e.remap)
    if (t || e.remap)
      `CHK(prog_addr, e)
    @(posedge sys_clk);
  endtask

  // Byte offset of entry k of a 16-entry word buffer walked in mirrored index order.
  function automatic logic [15:0] boff(input int k);
    return {11'h000, k[0], k[1], k[2], k[3], 1'b0};
  endfunction

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------
  // Test sequence
  // ------------
  initial begin
    {sys_clk, rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
      axi_rd(5'(i * 4), (i == 0) ? 32'h0000_00FF : 32'h0, 2'h0);
    axi_rd(5'h02, 32'h0, 2'h2);
    axi_wr(5'h06, 32'h0000_1234, 2'h2);
    axi_wr(5'h08, 32'hFFFF_FFA5, 2'h0);
    axi_rd(5'h08, 32'h0000_00A5, 2'h0);
    done("registers");
    axi_wr(5'h10, 32'h0000_1100, 2'h0);
    axi_wr(5'h14, 32'h0000_110F, 2'h0);
    foreach (sel[i]) begin
      axi_wr(5'h00, {16'h0000, 12'h8FF, sel[i]}, 2'h0);
      agu(0, sel[i], 16'h110C, 16'h0006, m_prei, 16'h1102, 16'h1102, 1'b1);
      agu(0, sel[i] + 4'h1, 16'h110C, 16'h0006, m_prei, 16'h1112, 16'h1112, 1'b1);
      agu(1, sel[i], 16'h110E, 16'h0002, m_posti, 16'h110E, 16'h1100, 1'b1);
    end
    agu(0, 4'h3, 16'h1100, 16'h0002, m_postd, 16'h1100, 16'h110E, 1'b1);
    agu(0, 4'h3, 16'h1102, 16'h0004, m_pred, 16'h110E, 16'h110E, 1'b1);
    agu(0, 4'h3, 16'h110E, 16'h0004, m_ofs, 16'h1102, 16'h0000, 1'b0);
    agu(0, 4'h3, 16'h1104, 16'h0002, m_ind, 16'h1104, 16'h0000, 1'b0);
    axi_wr(5'h00, 32'h0000_0FF3, 2'h0);
    agu(0, 4'h3, 16'h110C, 16'h0006, m_prei, 16'h1112, 16'h1112, 1'b1);
    axi_wr(5'h00, 32'h0000_8FFF, 2'h0);
    agu(1, 4'hF, 16'h110C, 16'h0006, m_prei, 16'h1112, 16'h1112, 1'b1);
    axi_wr(5'h18, 32'h0000_2000, 2'h0);
    axi_wr(5'h1C, 32'h0000_2007, 2'h0);
    axi_wr(5'h00, 32'h0000_4F5F, 2'h0);
    agu(2, 4'h5, 16'h2006, 16'h0002, m_prei, 16'h2000, 16'h2000, 1'b1);
    axi_wr(5'h00, 32'h0000_0F5F, 2'h0);
    agu(2, 4'h5, 16'h2006, 16'h0002, m_prei, 16'h2008, 16'h2008, 1'b1);
    done("modulo");
    axi_wr(5'h00, 32'h0000_02FF, 2'h0);
    axi_wr(5'h04, 32'h0000_8008, 2'h0);
    axi_rd(5'h04, 32'h0000_8008, 2'h0);
    for (int k = 0; k < 16; k++)
      agu(1, 4'h2, base + boff(k), 16'h0002, m_posti, base + boff(k), base + boff(k + 1), 1'b1);
    agu(1, 4'h2, 16'h1200, 16'h0002, m_prei, 16'h1210, 16'h1210, 1'b1);
    agu(1, 4'h2, 16'h1211, 16'h0002, m_posti, 16'h1210, 16'h1208, 1'b1);
    agu(3, 4'h2, 16'h1200, 16'h0001, m_posti, 16'h1200, 16'h1201, 1'b1);
    agu(1, 4'h2, 16'h1202, 16'h0002, m_postd, 16'h1202, 16'h1200, 1'b1);
    agu(0, 4'h2, 16'h1200, 16'h0002, m_posti, 16'h1200, 16'h1202, 1'b1);
    agu(1, 4'h3, 16'h1200, 16'h0002, m_posti, 16'h1200, 16'h1202, 1'b1);
    agu(1, 4'h2, 16'h1200, 16'h0002, m_ofs, 16'h1202, 16'h0000, 1'b0);
    axi_wr(5'h04, 32'h0000_0008, 2'h0);
    agu(1, 4'h2, 16'h1200, 16'h0002, m_posti, 16'h1200, 16'h1202, 1'b1);
    axi_wr(5'h04, 32'h0000_8008, 2'h0);
    // A spare cycle keeps the reversal pointer idle after the modifier is rewritten.
    @(posedge sys_clk);
    axi_wr(5'h00, 32'h0000_0FFF, 2'h0);
    agu(1, 4'hF, 16'h1200, 16'h0002, m_posti, 16'h1200, 16'h1202, 1'b1);
    axi_wr(5'h10, 32'h0000_1200, 2'h0);
    axi_wr(5'h14, 32'h0000_1207, 2'h0);
    axi_wr(5'h00, 32'h0000_8202, 2'h0);
    agu(1, 4'h2, 16'h1200, 16'h0002, m_posti, 16'h1200, 16'h1210, 1'b1);
    agu(0, 4'h2, 16'h1206, 16'h0002, m_prei, 16'h1200, 16'h1200, 1'b1);
    done("bit reverse");
    axi_wr(5'h08, 32'h0000_0085, 2'h0);
    axi_wr(5'h0C, 32'h0000_0003, 2'h0);
    prg(16'h9235, 1'b1, 1'b1, '{24'h859235, 1'b1, 1'b0, 1'b0});
    prg(16'h9234, 1'b0, 1'b1, '{24'h019234, 1'b0, 1'b1, 1'b1});
    prg(16'h9234, 1'b0, 1'b0, '{24'h000000, 1'b0, 1'b0, 1'b0});
    prg(16'h1234, 1'b0, 1'b1, '{24'h000000, 1'b0, 1'b0, 1'b0});
    axi_wr(5'h08, 32'h0000_0005, 2'h0);
    axi_wr(5'h0C, 32'h0000_0002, 2'h0);
    prg(16'h1234, 1'b1, 1'b0, '{24'h051234, 1'b0, 1'b0, 1'b0});
    prg(16'hF234, 1'b0, 1'b1, '{24'h017234, 1'b0, 1'b1, 1'b1});
    done("program space");
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule
